//--- include/smc_pkg.sv
// Shared types and constants of the stepper motion command block.
// Assumes one system clock and one serial-link clock, both supplied by the chip.
package smc_pkg;

    localparam int POS_W = 16;
    localparam int SEC_W = 11;
    localparam int NIB_W = 4;
    localparam int SEC_SHIFT = POS_W - SEC_W;
    localparam logic [SEC_W-1:0] SEC_DISABLED = 11'h400;
    localparam logic [POS_W-1:0] TARGET_RESET = 16'h0000;
    localparam logic [POS_W-1:0] ACTUAL_RESET = 16'h0000;
    localparam logic SUPPLY_LOSS_RESET = 1'h1;
    localparam logic BYPASS_CLEARED = 1'h0;
    localparam logic BYPASS_FORCED = 1'h1;

    typedef enum logic [3:0] {
        CMD_NONE             = 4'h0,
        CMD_READ_STATUS_ONE  = 4'h1,
        CMD_READ_STATUS_TWO  = 4'h2,
        CMD_WRITE_TARGET     = 4'h3,
        CMD_GO_SAFE_TARGET   = 4'h4,
        CMD_REFERENCE_RUN    = 4'h5,
        CMD_ABRUPT_HALT      = 4'h6,
        CMD_RAMPED_HALT      = 4'h7,
        CMD_RELOAD_DEFAULTS  = 4'h8,
        CMD_WRITE_PARAMS     = 4'h9,
        CMD_ZERO_POSITIONS   = 4'hA
    } smc_cmd_code_t;

    typedef enum logic [2:0] {
        ST_STOPPED      = 3'h0,
        ST_MOVING       = 3'h1,
        ST_REF_RUN      = 3'h2,
        ST_RAMPED_HALT  = 3'h3,
        ST_ABRUPT_HALT  = 3'h4,
        ST_SHUTDOWN     = 3'h5
    } smc_state_t;

    typedef struct packed {
        logic                   ramp_bypass_select;
        logic [NIB_W-1:0]       moving_current;
        logic [NIB_W-1:0]       standstill_current;
        logic [NIB_W-1:0]       start_velocity;
        logic [NIB_W-1:0]       top_velocity;
        logic                   direction_select;
        logic [NIB_W-1:0]       ramp_rate;
        logic [SEC_W-1:0]       secure_position;
        logic [1:0]             microstep_select;
    } smc_params_t;

    typedef struct packed {
        smc_cmd_code_t          code;
        logic [POS_W-1:0]       position;
        logic [POS_W-1:0]       position_two;
        logic                   ref_has_velocity;
        logic [NIB_W-1:0]       ref_top_velocity;
        logic [NIB_W-1:0]       ref_start_velocity;
        smc_params_t            params;
    } smc_cmd_t;

    typedef struct packed {
        logic                   cp_fail;
        logic                   undervolt_trip;
        logic                   wiring_fault;
        logic                   thermal_trip;
    } smc_faults_t;

    typedef struct packed {
        logic [POS_W-1:0]       target_position;
        logic [NIB_W-1:0]       top_velocity;
        logic [NIB_W-1:0]       start_velocity;
        logic [NIB_W-1:0]       ramp_rate;
        logic                   ramp_bypass_select;
        logic                   direction_select;
        logic [1:0]             microstep_select;
        logic [NIB_W-1:0]       coil_current;
        logic                   running;
        logic                   abrupt;
        logic                   bridge_off;
    } smc_drive_t;

    typedef struct packed {
        smc_state_t             state;
        logic                   supply_loss_flag;
        logic                   lost_step_flag;
        logic                   abrupt_halt_request_flag;
        logic                   thermal_flag;
        logic                   secure_enable;
        logic                   stop_origin;
        smc_params_t            params;
        logic [POS_W-1:0]       actual_position;
        logic [POS_W-1:0]       target_position;
    } smc_status_t;

endpackage : smc_pkg

//--- rtl/smc_motion_fsm.sv
// Motion state machine, command ranking, position and parameter registers.
// Commands arrive on the link clock from the serial framing logic; the ramp
// generator, fault monitors and one-time-programmable words sit outside.
`timescale 1ns/1ps

// How it works
// - Safe-target command copies secure position to target when enabled; Stopped starts moving.
// - Charge pump, undervoltage or wiring fault sets abrupt-halt flag and halts.
// - Thermal trip: Stopped goes Shutdown, moving or reference run ramp down.
// - Reset enters Shutdown; leaving needs a status-one read first.
// - Shutdown is left only with thermal and abrupt-halt flags both clear.
// - Flags other than stop-origin clear only after a status-one read and with their cause gone.
// - Reference run uses its own parameters, defaults taken from RAM at start.
// - Second reference motion forces bypass to one; reloaded zero applies afterwards.
// - Status read during reference run reports RAM velocities, not run values.
// - Velocity, ramp and bypass values written during reference run apply from next write-target; direction, microstep and currents at once.
// - Secure enable is high unless secure position is the most negative code.
// - Stop-origin flag sets leaving a halt state, clears first edge in Stopped.
// - Stopped with actual differing from target and stop-origin clear enters moving, lowest priority.
// - Lost-step flag blocks write-target and safe-target commands in every state.
// - Lost-step flag clears only by a status-one read.
// - Parameter registers load from programmable memory at start and stay writable.
// - Actual position is a sixteen-bit signed step count.
// - Target position is sixteen-bit signed, reset to zero.
// - Bypass zero ramps with ramp rate; one runs straight at start velocity.
// - Secure position is the upper eleven bits; lower bits load as zero.
// - Standstill current applies at rest, moving current during motion.
// - Abrupt halt outranks ramped halt and target reached.
// - Motion finished has lowest priority among a state's events.
module smc_motion_fsm
    import smc_pkg::*;
(
    // System clock, reset and freeze
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    // Serial link command side
    input  wire logic        i_link_clk,
    input  wire logic        i_cmd_valid,
    input  wire smc_cmd_t    i_cmd,
    output logic             o_cmd_ready,
    // Fault monitor pins
    input  wire smc_faults_t i_faults,
    // Programmable memory defaults
    input  wire smc_params_t i_otp_params,
    // Ramp generator
    input  wire logic        i_step,
    input  wire logic        i_step_down,
    input  wire logic        i_motion_done,
    output smc_drive_t       o_drive,
    // Status for the serial responder
    output smc_status_t      o_status,
    output logic             o_secure_enable
);

    function automatic logic [POS_W-1:0] sec_to_pos(input logic [SEC_W-1:0] sec);
        sec_to_pos = {sec, {SEC_SHIFT{1'b0}}};
    endfunction : sec_to_pos

    // ---------------- Link domain: hold command, toggle request ----------------
    logic       lnk_rst_meta;
    logic       lnk_rst_n;
    logic       lnk_req;
    logic       lnk_ack_meta;
    logic       lnk_ack;
    smc_cmd_t   lnk_cmd;
    logic       sys_ack;

    always_ff @(posedge i_link_clk) begin
        lnk_rst_meta <= i_rst_n;
        lnk_rst_n    <= lnk_rst_meta;
    end

    always_ff @(posedge i_link_clk) begin
        if (!lnk_rst_n) begin
            lnk_ack_meta <= 1'h0;
            lnk_ack      <= 1'h0;
        end else begin
            lnk_ack_meta <= sys_ack;
            lnk_ack      <= lnk_ack_meta;
        end
    end

    assign o_cmd_ready = lnk_rst_n && (lnk_req == lnk_ack);

    // The held word stays still until the system side has acknowledged it.
    always_ff @(posedge i_link_clk) begin
        if (!lnk_rst_n) begin
            lnk_req <= 1'h0;
            lnk_cmd <= '0;
        end else if (i_cmd_valid && o_cmd_ready) begin
            lnk_req <= ~lnk_req;
            lnk_cmd <= i_cmd;
        end
    end

    // ---------------- System domain: synchronisers ----------------
    logic        req_meta;
    logic        req_sync;
    smc_faults_t flt_meta;
    smc_faults_t flt;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            req_meta <= 1'h0;
            req_sync <= 1'h0;
            flt_meta <= '0;
            flt      <= '0;
        end else if (i_ce) begin
            req_meta <= lnk_req;
            req_sync <= req_meta;
            flt_meta <= i_faults;
            flt      <= flt_meta;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sys_ack <= 1'h0;
        end else if (i_ce) begin
            sys_ack <= req_sync;
        end
    end

    logic     cmd_take;
    smc_cmd_t cmd;
    assign cmd_take = i_ce && (req_sync != sys_ack);
    assign cmd      = lnk_cmd;

    logic c_read;
    logic c_target;
    logic c_safe;
    logic c_ref;
    logic c_abrupt;
    logic c_ramped;
    logic c_reload;
    logic c_params;
    logic c_zero;
    assign c_read   = cmd_take && (cmd.code == CMD_READ_STATUS_ONE);
    assign c_target = cmd_take && (cmd.code == CMD_WRITE_TARGET);
    assign c_safe   = cmd_take && (cmd.code == CMD_GO_SAFE_TARGET);
    assign c_ref    = cmd_take && (cmd.code == CMD_REFERENCE_RUN);
    assign c_abrupt = cmd_take && (cmd.code == CMD_ABRUPT_HALT);
    assign c_ramped = cmd_take && (cmd.code == CMD_RAMPED_HALT);
    assign c_reload = cmd_take && (cmd.code == CMD_RELOAD_DEFAULTS);
    assign c_params = cmd_take && (cmd.code == CMD_WRITE_PARAMS);
    assign c_zero   = cmd_take && (cmd.code == CMD_ZERO_POSITIONS);

    // ---------------- Registers ----------------
    smc_state_t       state;
    smc_state_t       next_state;
    smc_params_t      ram;
    smc_params_t      active;
    logic             init_pending;
    logic [POS_W-1:0] actual_position;
    logic [POS_W-1:0] target_position;
    logic [POS_W-1:0] next_target;
    logic [POS_W-1:0] ref_second_target;
    logic [NIB_W-1:0] ref_top;
    logic [NIB_W-1:0] ref_start;
    logic             ref_second;
    logic             supply_loss_flag;
    logic             lost_step_flag;
    logic             abrupt_halt_request_flag;
    logic             thermal_flag;
    logic             stop_origin;
    logic             next_hs;
    logic             next_tsd;
    logic             elec_fault;
    logic             block_target;

    assign o_secure_enable = (ram.secure_position != SEC_DISABLED);
    assign elec_fault      = flt.cp_fail | flt.undervolt_trip | flt.wiring_fault;
    assign block_target    = lost_step_flag;

    assign next_hs  = elec_fault | (abrupt_halt_request_flag & ~c_read);
    assign next_tsd = flt.thermal_trip | (thermal_flag & ~c_read);

    always_comb begin
        next_state  = state;
        next_target = target_position;
        unique case (state)
            ST_STOPPED: begin
                if (next_hs) begin
                    next_state = ST_SHUTDOWN;
                end else if (next_tsd) begin
                    next_state = ST_SHUTDOWN;
                end else if (c_safe && o_secure_enable && !block_target) begin
                    next_target = sec_to_pos(ram.secure_position);
                    next_state  = ST_MOVING;
                end else if (c_target && !block_target) begin
                    next_target = cmd.position;
                    next_state  = ST_MOVING;
                end else if (c_ref) begin
                    next_target = cmd.position;
                    next_state  = ST_REF_RUN;
                end else if (c_zero) begin
                    next_target = TARGET_RESET;
                end else if (!stop_origin && actual_position != target_position) begin
                    next_state = ST_MOVING;
                end
            end
            ST_MOVING, ST_REF_RUN: begin
                if (next_hs || c_abrupt) begin
                    next_state = ST_ABRUPT_HALT;
                end else if (next_tsd || (c_ramped && state == ST_MOVING)) begin
                    next_state = ST_RAMPED_HALT;
                end else if (c_safe && o_secure_enable && !block_target) begin
                    next_target = sec_to_pos(ram.secure_position);
                end else if (c_target && !block_target) begin
                    next_target = cmd.position;
                end else if (i_motion_done) begin
                    if (state == ST_REF_RUN && !ref_second) begin
                        next_target = ref_second_target;
                    end else begin
                        next_state = ST_STOPPED;
                    end
                end
            end
            ST_RAMPED_HALT: begin
                if (next_hs || c_abrupt) begin
                    next_state = ST_ABRUPT_HALT;
                end else if (i_motion_done) begin
                    next_state  = ST_STOPPED;
                    next_target = actual_position;
                end
            end
            ST_ABRUPT_HALT: begin
                if (i_motion_done) begin
                    next_state  = ST_STOPPED;
                    next_target = actual_position;
                end
            end
            ST_SHUTDOWN: begin
                if (c_read && !next_hs && !next_tsd) begin
                    next_state = ST_STOPPED;
                end
                if (c_zero) begin
                    next_target = TARGET_RESET;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state <= ST_SHUTDOWN;
        end else if (i_ce) begin
            state <= next_state;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            target_position <= TARGET_RESET;
        end else if (i_ce) begin
            target_position <= next_target;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            actual_position <= ACTUAL_RESET;
        end else if (i_ce) begin
            if (c_zero && (state == ST_STOPPED || state == ST_SHUTDOWN)) begin
                actual_position <= ACTUAL_RESET;
            end else if (i_step) begin
                actual_position <= i_step_down ? actual_position - 16'h0001
                                               : actual_position + 16'h0001;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ram          <= '0;
            init_pending <= 1'h1;
        end else if (i_ce) begin
            init_pending <= 1'h0;
            if (init_pending || c_reload) begin
                ram                    <= i_otp_params;
                ram.ramp_bypass_select <= BYPASS_CLEARED;
            end else if (c_params) begin
                ram <= cmd.params;
            end
        end
    end

    // motion parameters latch on new targets in Moving and on Stopped to Moving
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            active <= '0;
        end else if (i_ce && next_state == ST_MOVING && next_target != target_position) begin
            active <= ram;
        end else if (i_ce && state == ST_STOPPED && next_state == ST_MOVING) begin
            active <= ram;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ref_top           <= '0;
            ref_start         <= '0;
            ref_second_target <= '0;
            ref_second        <= 1'h0;
        end else if (i_ce) begin
            if (state == ST_STOPPED && next_state == ST_REF_RUN) begin
                ref_top           <= cmd.ref_has_velocity ? cmd.ref_top_velocity
                                                          : ram.top_velocity;
                ref_start         <= cmd.ref_has_velocity ? cmd.ref_start_velocity
                                                          : ram.start_velocity;
                ref_second_target <= cmd.position_two;
                ref_second        <= 1'h0;
            end else if (state == ST_REF_RUN && i_motion_done) begin
                ref_second <= 1'h1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            abrupt_halt_request_flag <= 1'h0;
            thermal_flag             <= 1'h0;
            supply_loss_flag         <= SUPPLY_LOSS_RESET;
        end else if (i_ce) begin
            abrupt_halt_request_flag <= next_hs;
            thermal_flag             <= next_tsd;
            if (c_read) begin
                supply_loss_flag <= 1'h0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            lost_step_flag <= 1'h0;
        end else if (i_ce) begin
            if (elec_fault || flt.thermal_trip || (next_state == ST_ABRUPT_HALT
                    && state != ST_ABRUPT_HALT)) begin
                lost_step_flag <= 1'h1;
            end else if (c_read) begin
                lost_step_flag <= 1'h0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            stop_origin <= 1'h0;
        end else if (i_ce) begin
            if ((state == ST_RAMPED_HALT || state == ST_ABRUPT_HALT) && next_state != state) begin
                stop_origin <= 1'h1;
            end else if (state == ST_STOPPED) begin
                stop_origin <= 1'h0;
            end
        end
    end

    // ---------------- Drive and status outputs ----------------
    logic in_ref;
    logic running;
    assign in_ref  = (state == ST_REF_RUN);
    assign running = (state == ST_MOVING) || in_ref
                  || (state == ST_RAMPED_HALT) || (state == ST_ABRUPT_HALT);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_drive <= '0;
        end else if (i_ce) begin
            o_drive.target_position  <= target_position;
            o_drive.top_velocity     <= in_ref ? ref_top : active.top_velocity;
            o_drive.start_velocity   <= in_ref ? ref_start : active.start_velocity;
            o_drive.ramp_rate        <= active.ramp_rate;
            o_drive.ramp_bypass_select <= (in_ref && ref_second) ? BYPASS_FORCED
                                                                 : active.ramp_bypass_select;
            o_drive.direction_select <= ram.direction_select;
            o_drive.microstep_select <= ram.microstep_select;
            o_drive.coil_current     <= running ? ram.moving_current
                                                : ram.standstill_current;
            o_drive.running          <= running;
            o_drive.abrupt           <= (state == ST_ABRUPT_HALT);
            o_drive.bridge_off       <= (state == ST_SHUTDOWN);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_status       <= '0;
            o_status.state <= ST_SHUTDOWN;
        end else if (i_ce) begin
            o_status.state                    <= state;
            o_status.supply_loss_flag         <= supply_loss_flag;
            o_status.lost_step_flag           <= lost_step_flag;
            o_status.abrupt_halt_request_flag <= abrupt_halt_request_flag;
            o_status.thermal_flag             <= thermal_flag;
            o_status.secure_enable            <= o_secure_enable;
            o_status.stop_origin              <= stop_origin;
            o_status.params                   <= ram;
            o_status.actual_position          <= actual_position;
            o_status.target_position          <= target_position;
        end
    end

endmodule : smc_motion_fsm

//--- sim/smc_motion_fsm_checker.sv
// Assertions on the status outputs of the motion block.
// Assumes o_status lags internal state by one enabled clock.
`timescale 1ns/1ps
module smc_motion_fsm_checker
    import smc_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire smc_faults_t i_faults,
    input wire smc_status_t o_status,
    input wire logic        o_secure_enable
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    smc_state_t st;
    assign st = o_status.state;
    a_reset_state: assert property ($rose(i_rst_n) |-> st == ST_SHUTDOWN)
        else $error("state after reset is not shutdown");
    a_reset_target: assert property ($rose(i_rst_n) |-> o_status.target_position == TARGET_RESET)
        else $error("target after reset is not zero");
    a_stop_clear: assert property (st == ST_STOPPED && $past(st) == ST_STOPPED |-> !o_status.stop_origin)
        else $error("stop origin still set in stopped");
    a_halt_origin: assert property (st == ST_STOPPED && $past(st) inside {ST_RAMPED_HALT, ST_ABRUPT_HALT}
        |-> o_status.stop_origin)
        else $error("stop origin not set after halt");
    a_fault_flag: assert property (i_faults.wiring_fault |-> ##[1:5] o_status.abrupt_halt_request_flag)
        else $error("abrupt halt flag not raised by fault");
    a_thermal_stop: assert property ($rose(i_faults.thermal_trip) && st == ST_STOPPED
        |-> ##[2:6] st == ST_SHUTDOWN)
        else $error("thermal trip did not shut down");
    a_shutdown_exit: assert property ($past(st) == ST_SHUTDOWN && st != ST_SHUTDOWN
        |-> !o_status.thermal_flag && !o_status.abrupt_halt_request_flag)
        else $error("shutdown left with a flag set");
    a_secure_enable: assert property ($past(i_rst_n, 3)
        |=> (o_status.params.secure_position != SEC_DISABLED) == $past(o_secure_enable))
        else $error("secure enable disagrees with secure position");
    c_abrupt: cover property (st == ST_ABRUPT_HALT);
    c_ramped: cover property (st == ST_RAMPED_HALT);
    c_exit: cover property ($past(st) == ST_SHUTDOWN && st == ST_STOPPED);
endmodule : smc_motion_fsm_checker

bind smc_motion_fsm smc_motion_fsm_checker u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_faults(i_faults), .o_status(o_status), .o_secure_enable(o_secure_enable));

//--- sim/smc_host_model.sv
// Host end of the command link: presents one whole command word at a time.
// Assumes ready is driven from the link clock domain.
`timescale 1ns/1ps
module smc_host_model
    import smc_pkg::*;
(
    input  wire logic i_link_clk,
    input  wire logic i_cmd_ready,
    output logic      o_cmd_valid,
    output smc_cmd_t  o_cmd
);
    initial begin
        o_cmd_valid = 1'h0;
        o_cmd = '0;
    end
    task automatic send(input smc_cmd_t c);
        @(posedge i_link_clk);
        while (!i_cmd_ready) @(posedge i_link_clk);
        o_cmd_valid <= 1'h1;
        o_cmd       <= c;
        @(posedge i_link_clk);
        while (!i_cmd_ready) @(posedge i_link_clk);
        o_cmd_valid <= 1'h0;
        // Released data lines show the inverse so stale values are never trusted.
        o_cmd       <= ~c;
    endtask : send
endmodule : smc_host_model

//--- sim/tb_top.sv
// Self-checking bench for the motion state machine.
// Assumes the host model drives the link; faults and ramp pulses come from here.
`timescale 1ns/1ps
module tb_top;
    import smc_pkg::*;
    logic        i_clk = 1'h0;
    logic        i_link_clk = 1'h0;
    logic        i_rst_n = 1'h0;
    logic        i_cmd_valid, o_cmd_ready, o_secure_enable;
    logic        i_step = 1'h0;
    logic        i_step_down = 1'h0;
    logic        i_motion_done = 1'h0;
    smc_cmd_t    i_cmd;
    smc_faults_t i_faults = '0;
    smc_params_t otp;
    smc_drive_t  o_drive;
    smc_status_t o_status;
    logic [31:0] seed = 32'hC34C274D;
    logic [31:0] nxt;
    logic [15:0] exp_tgt = 16'h0000;
    logic [15:0] exp_act = 16'h0000;
    logic [18:0] exp_q[$];
    smc_state_t  last = ST_SHUTDOWN;
    int          bad_count = 0;
    int          total_checks = 0;
    always #12.5 i_clk = ~i_clk;
    initial #3 forever #6 i_link_clk = ~i_link_clk;
    smc_motion_fsm dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'h1), .i_link_clk(i_link_clk),
        .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready), .i_faults(i_faults),
        .i_otp_params(otp), .i_step(i_step), .i_step_down(i_step_down),
        .i_motion_done(i_motion_done), .o_drive(o_drive), .o_status(o_status),
        .o_secure_enable(o_secure_enable));
    smc_host_model host (.i_link_clk(i_link_clk), .i_cmd_ready(o_cmd_ready),
        .o_cmd_valid(i_cmd_valid), .o_cmd(i_cmd));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input string name, input logic [18:0] seen, input logic [18:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done
    task automatic expect_st(input smc_state_t s);
        exp_q.push_back({s, exp_tgt});
    endtask : expect_st
    task automatic cmd(input smc_cmd_code_t code, input logic [15:0] pos);
        smc_cmd_t c;
        seed = lfsr(seed);
        c = {code, pos, seed[15:0], 1'h0, seed[23:16], otp};
        host.send(c);
        repeat (12) @(negedge i_clk);
    endtask : cmd
    task automatic pulse(input int n, input logic done);
        repeat (n) begin
            @(negedge i_clk);
            seed = lfsr(seed);
            i_step = ~done;
            i_step_down = seed[0];
            i_motion_done = done;
            if (!done) exp_act = seed[0] ? exp_act - 16'h0001 : exp_act + 16'h0001;
            @(negedge i_clk);
            i_step = 1'h0;
            i_motion_done = 1'h0;
        end
        repeat (6) @(negedge i_clk);
    endtask : pulse
    // Every state change of the status snapshot consumes the oldest expectation.
    always @(negedge i_clk) begin
        if (i_rst_n && o_status.state !== last) begin
            last = o_status.state;
            if (exp_q.size() == 0) check("unexpected state", {last, o_status.target_position}, '1);
            else check("state and target", {last, o_status.target_position}, exp_q.pop_front());
        end
    end
    initial begin
        #1000000;
        bad_count++;
        test_done();
    end
    initial begin
        otp = {seed, 3'h5};
        otp.secure_position = 11'h2A5;
        repeat (6) @(negedge i_clk);
        i_rst_n = 1'h1;
        repeat (20) @(negedge i_clk);
        check("supply loss", o_status.supply_loss_flag, 1'h1);
        expect_st(ST_STOPPED);
        cmd(CMD_READ_STATUS_ONE, 16'h0000);
        exp_tgt = 16'h0123;
        expect_st(ST_MOVING);
        cmd(CMD_WRITE_TARGET, exp_tgt);
        pulse(5, 1'h0);
        expect_st(ST_ABRUPT_HALT);
        cmd(CMD_ABRUPT_HALT, 16'h0000);
        pulse(3, 1'h0);
        exp_tgt = exp_act;
        expect_st(ST_STOPPED);
        pulse(1, 1'h1);
        cmd(CMD_WRITE_TARGET, 16'h7000);
        check("lost step", o_status.lost_step_flag, 1'h1);
        check("target kept", o_status.target_position, exp_tgt);
        cmd(CMD_READ_STATUS_ONE, 16'h0000);
        check("lost step", o_status.lost_step_flag, 1'h0);
        check("secure enable", o_secure_enable, 1'h1);
        exp_tgt = {otp.secure_position, 5'h00};
        expect_st(ST_MOVING);
        cmd(CMD_GO_SAFE_TARGET, 16'h0000);
        expect_st(ST_RAMPED_HALT);
        cmd(CMD_RAMPED_HALT, 16'h0000);
        pulse(2, 1'h0);
        exp_tgt = exp_act;
        expect_st(ST_STOPPED);
        pulse(1, 1'h1);
        otp.secure_position = SEC_DISABLED;
        cmd(CMD_WRITE_PARAMS, 16'h0000);
        check("secure enable", o_secure_enable, 1'h0);
        cmd(CMD_GO_SAFE_TARGET, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            expect_st(ST_SHUTDOWN);
            i_faults = smc_faults_t'(4'h1 << k);
            repeat (8) @(negedge i_clk);
            cmd(CMD_READ_STATUS_ONE, 16'h0000);
            i_faults = '0;
            expect_st(ST_STOPPED);
            cmd(CMD_READ_STATUS_ONE, 16'h0000);
            cmd(CMD_READ_STATUS_ONE, 16'h0000);
        end
        cmd(CMD_RELOAD_DEFAULTS, 16'h0000);
        check("bypass reload", o_status.params.ramp_bypass_select, 1'h0);
        nxt = lfsr(seed);
        exp_tgt = 16'h0040;
        expect_st(ST_REF_RUN);
        cmd(CMD_REFERENCE_RUN, exp_tgt);
        pulse(1, 1'h1);
        check("bypass forced", o_drive.ramp_bypass_select, 1'h1);
        check("ref target", o_drive.target_position, nxt[15:0]);
        exp_tgt = nxt[15:0];
        expect_st(ST_ABRUPT_HALT);
        cmd(CMD_ABRUPT_HALT, 16'h0000);
        exp_tgt = exp_act;
        expect_st(ST_STOPPED);
        pulse(1, 1'h1);
        expect_st(ST_MOVING);
        pulse(1, 1'h0);
        check("queue empty", 19'(exp_q.size()), 19'h0);
        test_done();
    end
endmodule : tb_top
